// ---- common/skip_sub_pkg.sv ----
package skip_sub_pkg;

   // operation codes handed over by the decoder
   typedef enum logic [4:0] {
      OP_NONE                 = 5'h00,
      OP_SUB_BORROW_MEM       = 5'h01,
      OP_DEC_SKIP_ZERO        = 5'h02,
      OP_DEC_TO_WORK_SKIP     = 5'h03,
      OP_SET_BYTE             = 5'h04,
      OP_SET_BIT              = 5'h05,
      OP_INC_SKIP_ZERO        = 5'h06,
      OP_INC_TO_WORK_SKIP     = 5'h07,
      OP_SKIP_NONZERO         = 5'h08,
      OP_SKIP_NONZERO_BIT     = 5'h09,
      OP_MINUS_TO_WORK        = 5'h0a,
      OP_MINUS_TO_MEMORY      = 5'h0b,
      OP_MINUS_IMM_TO_WORK    = 5'h0c,
      OP_NIBBLE_EXCHANGE      = 5'h0d,
      OP_NIBBLE_EXCHANGE_WORK = 5'h0e,
      OP_SKIP_IF_NULL         = 5'h0f,
      OP_LOAD_WORK_SKIP_NULL  = 5'h10,
      OP_SKIP_IF_NULL_BIT     = 5'h11
   } op_t;

   // sequencer states, one-hot
   typedef enum logic [1:0] {
      FSM_RUN   = 2'h1,
      FSM_DUMMY = 2'h2
   } fsm_t;

   localparam int BYTE_W = 8;
   localparam int NIB_W = 4;
   localparam int MSB = 7;
   localparam int BIT_SEL_W = 3;

   // flag vector layout
   localparam int FLAG_W = 6;
   localparam int FLG_WRAP = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_NIB = 2;
   localparam int FLG_C = 3;
   localparam int FLG_SIGN = 4;
   localparam int FLG_MZ = 5;

   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [7:0] BYTE_NULL = 8'h00;
   localparam logic [7:0] STEP_ONE = 8'h01;
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic [5:0] FLAGS_RESET = 6'h00;

   typedef struct packed {
      fsm_t fsm;
      logic ready;
      logic dummy;
      logic skip;
      logic mem_we;
      logic [7:0] mem_wdata;
      logic [7:0] work;
      logic [5:0] flags;
   } state_t;

   localparam state_t STATE_RESET = '{
      fsm: FSM_RUN, ready: 1'b1, dummy: 1'b0, skip: 1'b0, mem_we: 1'b0,
      mem_wdata: BYTE_NULL, work: WORK_RESET, flags: FLAGS_RESET};

endpackage

// ---- hdl/bit_unit.sv ----
`timescale 1ns/1ps
// byte tests, bit select, bit set and nibble swap
module bit_unit import skip_sub_pkg::*; (
   input wire logic [7:0] data,
   input wire logic [2:0] bit_sel,
   output logic byte_zero,
   output logic bit_val,
   output logic [7:0] with_bit_set,
   output logic [7:0] swapped
);

   // one decoded lane per data bit
   genvar i;
   generate
      for (i = 0; i < BYTE_W; i++) begin : g_lane
         assign with_bit_set[i] = data[i] | (bit_sel == BIT_SEL_W'(i));
      end
   endgenerate

   assign byte_zero = (data == BYTE_NULL);
   assign bit_val = data[bit_sel];
   assign swapped = {data[NIB_W-1:0], data[BYTE_W-1:NIB_W]};

endmodule // bit_unit

// ---- hdl/skip_sub_core.sv ----
// Summary of operation
// - subtract with borrow: memory gets work minus operand minus inverted borrow bit.
// - borrow bit cleared on negative result, set on positive or zero.
// - subtractions update wrap, null, nibble, borrow, sign and multibyte flags.
// - dec_skip_zero stores memory minus one, skips when the new value is zero.
// - dec_to_work_skip_zero puts memory minus one in work, skips on zero.
// - a taken skip adds one dummy cycle while the next fetch happens.
// - set byte writes all ones, flags untouched.
// - set bit forces the selected bit to one, flags untouched.
// - inc_skip_zero stores memory plus one, skips on zero, no flag change.
// - inc_to_work_skip_zero loads memory plus one into work, skips on zero.
// - skip_nonzero skips when the byte or selected bit is non-zero.
// - minus_to_work with memory operand stores work minus memory in work.
// - minus_to_memory writes work minus memory to memory, work kept.
// - minus_to_work immediate stores work minus immediate in work.
// - nibble_exchange swaps the halves of the memory byte in place.
// - nibble_exchange_to_work writes the swapped byte into work only.
// - skip_if_null skips when the memory byte is zero, no flag change.
// - load_work_skip_null copies memory to work, skips when it is zero.
// - bit form of skip_if_null skips when the selected bit is zero.
`timescale 1ns/1ps
module skip_sub_core import skip_sub_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic op_valid,
   input wire op_t op_code,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] imm_data,
   input wire logic [2:0] bit_sel,
   output logic op_ready,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   output logic [7:0] work_register,
   output logic signed_wrap_flag,
   output logic result_null_flag,
   output logic nibble_carry_flag,
   output logic borrow_inverse_bit,
   output logic signed_result_flag,
   output logic multibyte_null_flag,
   output logic skip_taken,
   output logic dummy_cycle
);

   state_t st_ff;
   state_t nxt_st;
   logic accept;
   logic skip_now;
   logic use_imm;
   logic with_borrow;
   logic [7:0] sub_b;
   logic [7:0] diff;
   logic no_borrow;
   logic nib_no_borrow;
   logic wrap;
   logic diff_zero;
   logic [5:0] sub_flags;
   logic [7:0] dec_val;
   logic [7:0] inc_val;
   logic byte_zero;
   logic bit_val;
   logic [7:0] with_bit_set;
   logic [7:0] swapped;

   // an operation is taken only while not in the dummy slot
   assign accept = ce & op_valid & st_ff.ready;
   assign use_imm = (op_code == OP_MINUS_IMM_TO_WORK);
   assign with_borrow = (op_code == OP_SUB_BORROW_MEM);
   assign sub_b = use_imm ? imm_data : mem_rdata;
   assign dec_val = mem_rdata - STEP_ONE;
   assign inc_val = mem_rdata + STEP_ONE;

   sub_unit u_sub (
      .minuend(st_ff.work),
      .subtrahend(sub_b),
      .no_borrow_in(with_borrow ? st_ff.flags[FLG_C] : 1'b1),
      .diff(diff),
      .no_borrow_out(no_borrow),
      .nib_no_borrow(nib_no_borrow),
      .signed_wrap(wrap)
   );

   bit_unit u_bit (
      .data(mem_rdata),
      .bit_sel(bit_sel),
      .byte_zero(byte_zero),
      .bit_val(bit_val),
      .with_bit_set(with_bit_set),
      .swapped(swapped)
   );

   // flag set common to every subtraction
   always_comb begin
      diff_zero = (diff == BYTE_NULL);
      sub_flags = st_ff.flags;
      sub_flags[FLG_WRAP] = wrap;
      sub_flags[FLG_Z] = diff_zero;
      sub_flags[FLG_NIB] = nib_no_borrow;
      sub_flags[FLG_C] = no_borrow;
      // true sign survives an overflow
      sub_flags[FLG_SIGN] = diff[MSB] ^ wrap;
      // chained borrow keeps zero only if every byte so far was zero
      sub_flags[FLG_MZ] = with_borrow ? (diff_zero & st_ff.flags[FLG_MZ]) : diff_zero;
   end

   // next state: one operation per cycle, skip costs one dummy cycle
   always_comb begin
      nxt_st = st_ff;
      skip_now = 1'b0;
      nxt_st.mem_we = 1'b0;
      nxt_st.skip = 1'b0;
      case (st_ff.fsm)
         FSM_RUN: begin
            nxt_st.ready = 1'b1;
            nxt_st.dummy = 1'b0;
            if (accept) begin
               case (op_code)
                  OP_SUB_BORROW_MEM, OP_MINUS_TO_MEMORY: begin
                     nxt_st.mem_we = 1'b1;
                     nxt_st.mem_wdata = diff;
                     nxt_st.flags = sub_flags;
                  end
                  OP_MINUS_TO_WORK, OP_MINUS_IMM_TO_WORK: begin
                     nxt_st.work = diff;
                     nxt_st.flags = sub_flags;
                  end
                  OP_DEC_SKIP_ZERO: begin
                     nxt_st.mem_we = 1'b1;
                     nxt_st.mem_wdata = dec_val;
                     skip_now = (dec_val == BYTE_NULL);
                  end
                  OP_DEC_TO_WORK_SKIP: begin
                     nxt_st.work = dec_val;
                     skip_now = (dec_val == BYTE_NULL);
                  end
                  OP_INC_SKIP_ZERO: begin
                     nxt_st.mem_we = 1'b1;
                     nxt_st.mem_wdata = inc_val;
                     skip_now = (inc_val == BYTE_NULL);
                  end
                  OP_INC_TO_WORK_SKIP: begin
                     nxt_st.work = inc_val;
                     skip_now = (inc_val == BYTE_NULL);
                  end
                  OP_SET_BYTE: begin
                     nxt_st.mem_we = 1'b1;
                     nxt_st.mem_wdata = BYTE_ONES;
                  end
                  OP_SET_BIT: begin
                     nxt_st.mem_we = 1'b1;
                     nxt_st.mem_wdata = with_bit_set;
                  end
                  OP_SKIP_NONZERO: begin
                     skip_now = ~byte_zero;
                  end
                  OP_SKIP_NONZERO_BIT: begin
                     skip_now = bit_val;
                  end
                  OP_NIBBLE_EXCHANGE: begin
                     nxt_st.mem_we = 1'b1;
                     nxt_st.mem_wdata = swapped;
                  end
                  OP_NIBBLE_EXCHANGE_WORK: begin
                     nxt_st.work = swapped;
                  end
                  OP_SKIP_IF_NULL: begin
                     skip_now = byte_zero;
                  end
                  OP_LOAD_WORK_SKIP_NULL: begin
                     nxt_st.work = mem_rdata;
                     skip_now = byte_zero;
                  end
                  OP_SKIP_IF_NULL_BIT: begin
                     skip_now = ~bit_val;
                  end
                  default: begin
                     nxt_st.mem_we = 1'b0;
                  end
               endcase
               if (skip_now) begin
                  // hold off the decoder for the dummy slot
                  nxt_st.skip = 1'b1;
                  nxt_st.ready = 1'b0;
                  nxt_st.dummy = 1'b1;
                  nxt_st.fsm = FSM_DUMMY;
               end
            end
         end
         FSM_DUMMY: begin
            nxt_st.ready = 1'b1;
            nxt_st.dummy = 1'b0;
            nxt_st.fsm = FSM_RUN;
         end
         default: begin
            nxt_st = STATE_RESET;
         end
      endcase
   end

   // single state register, frozen while ce is low unless rst is high
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= STATE_RESET;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // all outputs straight from the state register
   assign op_ready = st_ff.ready;
   assign mem_we = st_ff.mem_we;
   assign mem_wdata = st_ff.mem_wdata;
   assign work_register = st_ff.work;
   assign signed_wrap_flag = st_ff.flags[FLG_WRAP];
   assign result_null_flag = st_ff.flags[FLG_Z];
   assign nibble_carry_flag = st_ff.flags[FLG_NIB];
   assign borrow_inverse_bit = st_ff.flags[FLG_C];
   assign signed_result_flag = st_ff.flags[FLG_SIGN];
   assign multibyte_null_flag = st_ff.flags[FLG_MZ];
   assign skip_taken = st_ff.skip;
   assign dummy_cycle = st_ff.dummy;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_borrow_sub_mem: assert property (
      accept && op_code == OP_SUB_BORROW_MEM |=> mem_we
      && mem_wdata == BYTE_W'($past(st_ff.work) - $past(mem_rdata)
      - {7'h00, ~$past(st_ff.flags[FLG_C])}))
      else $error("borrow subtract wrote wrong byte");

   a_borrow_bit: assert property (
      accept && op_code == OP_MINUS_TO_WORK
      |=> borrow_inverse_bit == ($past(st_ff.work) >= $past(mem_rdata)))
      else $error("borrow bit wrong after subtract");

   a_sub_null_sign: assert property (
      accept && op_code == OP_MINUS_IMM_TO_WORK
      |=> result_null_flag == (work_register == BYTE_NULL)
      && multibyte_null_flag == result_null_flag
      && signed_result_flag == (work_register[MSB] ^ signed_wrap_flag))
      else $error("subtract flags inconsistent with result");

   a_dec_mem: assert property (
      accept && op_code == OP_DEC_SKIP_ZERO
      |=> mem_we && mem_wdata == BYTE_W'($past(mem_rdata) - STEP_ONE)
      && skip_taken == ($past(mem_rdata) == STEP_ONE))
      else $error("decrement-skip wrong");

   a_dec_work: assert property (
      accept && op_code == OP_DEC_TO_WORK_SKIP
      |=> !mem_we && work_register == BYTE_W'($past(mem_rdata) - STEP_ONE)
      && skip_taken == (work_register == BYTE_NULL))
      else $error("decrement-to-work-skip wrong");

   a_skip_dummy: assert property (
      ce && skip_taken |-> dummy_cycle && !op_ready ##1 (op_ready && !dummy_cycle))
      else $error("skip did not insert exactly one dummy cycle");

   a_set_byte: assert property (
      accept && op_code == OP_SET_BYTE
      |=> mem_we && mem_wdata == BYTE_ONES && $stable(st_ff.flags))
      else $error("set byte wrong or flags moved");

   a_set_bit: assert property (
      accept && op_code == OP_SET_BIT
      |=> mem_we && mem_wdata == ($past(mem_rdata) | (STEP_ONE << $past(bit_sel)))
      && $stable(st_ff.flags))
      else $error("set bit wrong");

   a_inc_mem: assert property (
      accept && op_code == OP_INC_SKIP_ZERO
      |=> mem_wdata == BYTE_W'($past(mem_rdata) + STEP_ONE)
      && skip_taken == ($past(mem_rdata) == BYTE_ONES) && $stable(st_ff.flags))
      else $error("increment-skip wrong");

   a_inc_work: assert property (
      accept && op_code == OP_INC_TO_WORK_SKIP
      |=> !mem_we && work_register == BYTE_W'($past(mem_rdata) + STEP_ONE)
      && $stable(st_ff.flags))
      else $error("increment-to-work wrong");

   a_skip_nonzero: assert property (
      accept && op_code == OP_SKIP_NONZERO
      |=> skip_taken == ($past(mem_rdata) != BYTE_NULL) && !mem_we)
      else $error("skip on non-zero wrong");

   a_minus_mem: assert property (
      accept && op_code == OP_MINUS_TO_MEMORY
      |=> mem_we && $stable(work_register)
      && mem_wdata == BYTE_W'($past(st_ff.work) - $past(mem_rdata)))
      else $error("subtract to memory wrong");

   a_swap_mem: assert property (
      accept && op_code == OP_NIBBLE_EXCHANGE
      |=> mem_we && mem_wdata == {$past(mem_rdata[NIB_W-1:0]),
      $past(mem_rdata[BYTE_W-1:NIB_W])} && $stable(st_ff.flags))
      else $error("nibble exchange wrong");

   a_skip_null: assert property (
      accept && op_code == OP_SKIP_IF_NULL
      |=> skip_taken == ($past(mem_rdata) == BYTE_NULL) && $stable(st_ff.flags))
      else $error("skip on null wrong");

   a_load_skip: assert property (
      accept && op_code == OP_LOAD_WORK_SKIP_NULL
      |=> work_register == $past(mem_rdata)
      && skip_taken == (work_register == BYTE_NULL))
      else $error("load and skip wrong");

   a_null_bit: assert property (
      accept && op_code == OP_SKIP_IF_NULL_BIT
      |=> skip_taken == !$past(mem_rdata[bit_sel]) && $stable(st_ff.flags))
      else $error("skip on null bit wrong");

endmodule // skip_sub_core

// ---- hdl/sub_unit.sv ----
`timescale 1ns/1ps
// 8-bit subtractor with inverted-borrow input and output
module sub_unit import skip_sub_pkg::*; (
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   input wire logic no_borrow_in,
   output logic [7:0] diff,
   output logic no_borrow_out,
   output logic nib_no_borrow,
   output logic signed_wrap
);

   logic [8:0] full;
   logic [4:0] low;

   // add the one's complement so carry out means no borrow
   always_comb begin
      full = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, no_borrow_in};
      low = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~subtrahend[NIB_W-1:0]}
            + {4'h0, no_borrow_in};
      diff = full[BYTE_W-1:0];
      no_borrow_out = full[BYTE_W];
      nib_no_borrow = low[NIB_W];
      // operands of unlike sign and result sign differs from minuend
      signed_wrap = (minuend[MSB] ^ subtrahend[MSB]) & (diff[MSB] ^ minuend[MSB]);
   end

endmodule // sub_unit

// ---- sim/skip_subtract_swap_ops_tb_top.sv ----
`timescale 1ns/1ps
module skip_subtract_swap_ops_tb_top import skip_sub_pkg::*;;
   localparam int LIMIT = 5000;
   logic clk, rst, ce, op_valid, op_ready, mem_we, skip_taken, dummy_cycle;
   op_t op_code;
   logic [7:0] mem_rdata, imm_data, mem_wdata, work_register;
   logic [2:0] bit_sel;
   logic signed_wrap_flag, result_null_flag, nibble_carry_flag;
   logic borrow_inverse_bit, signed_result_flag, multibyte_null_flag;
   logic [5:0] flg, ef;
   logic [7:0] ew, ewd;
   int n_errors, num_checks, cycles;

   skip_sub_core dut (.clk(clk), .rst(rst), .ce(ce), .op_valid(op_valid), .op_code(op_code),
      .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel), .op_ready(op_ready),
      .mem_we(mem_we), .mem_wdata(mem_wdata), .work_register(work_register),
      .signed_wrap_flag(signed_wrap_flag), .result_null_flag(result_null_flag),
      .nibble_carry_flag(nibble_carry_flag), .borrow_inverse_bit(borrow_inverse_bit),
      .signed_result_flag(signed_result_flag), .multibyte_null_flag(multibyte_null_flag),
      .skip_taken(skip_taken), .dummy_cycle(dummy_cycle));

   // flag outputs gathered in the package's vector order
   assign flg = {multibyte_null_flag, signed_result_flag, borrow_inverse_bit,
                 nibble_carry_flag, result_null_flag, signed_wrap_flag};

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic wrap_up();
      if (n_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_errors = n_errors + 1;
         wrap_up();
      end
   end

   task automatic chk(logic [7:0] seen, logic [7:0] exp, string what);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // one op: reference result from the instruction set, then drive and judge
   task automatic run(op_t op, logic [7:0] m, logic [7:0] imm, logic [2:0] bs);
      logic [8:0] full;
      logic [4:0] nib;
      logic [7:0] b, d, r;
      logic cin, we, skp;
      b = (op == OP_MINUS_IMM_TO_WORK) ? imm : m;
      cin = (op == OP_SUB_BORROW_MEM) ? ef[FLG_C] : 1'b1;
      full = {1'b0, ew} - {1'b0, b} - {8'h00, ~cin};
      nib = {1'b0, ew[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
      d = full[7:0];
      we = 1'b0;
      skp = 1'b0;
      r = 8'h00;
      if (op inside {OP_SUB_BORROW_MEM, OP_MINUS_TO_WORK, OP_MINUS_TO_MEMORY,
                     OP_MINUS_IMM_TO_WORK}) begin
         ef[FLG_WRAP] = (ew[7] != b[7]) && (d[7] != ew[7]);
         ef[FLG_Z] = (d == 8'h00);
         ef[FLG_NIB] = ~nib[4];
         ef[FLG_C] = ~full[8];
         ef[FLG_SIGN] = d[7] ^ ef[FLG_WRAP];
         ef[FLG_MZ] = (op == OP_SUB_BORROW_MEM) ? (ef[FLG_Z] & ef[FLG_MZ]) : ef[FLG_Z];
      end
      case (op)
         OP_SUB_BORROW_MEM, OP_MINUS_TO_MEMORY: begin we = 1'b1; r = d; end
         OP_MINUS_TO_WORK, OP_MINUS_IMM_TO_WORK: ew = d;
         OP_DEC_SKIP_ZERO: begin we = 1'b1; r = m - 8'h01; skp = (r == 8'h00); end
         OP_DEC_TO_WORK_SKIP: begin ew = m - 8'h01; skp = (ew == 8'h00); end
         OP_SET_BYTE: begin we = 1'b1; r = 8'hff; end
         OP_SET_BIT: begin we = 1'b1; r = m | (8'h01 << bs); end
         OP_INC_SKIP_ZERO: begin we = 1'b1; r = m + 8'h01; skp = (r == 8'h00); end
         OP_INC_TO_WORK_SKIP: begin ew = m + 8'h01; skp = (ew == 8'h00); end
         OP_SKIP_NONZERO: skp = (m != 8'h00);
         OP_SKIP_NONZERO_BIT: skp = m[bs];
         OP_NIBBLE_EXCHANGE: begin we = 1'b1; r = {m[3:0], m[7:4]}; end
         OP_NIBBLE_EXCHANGE_WORK: ew = {m[3:0], m[7:4]};
         OP_SKIP_IF_NULL: skp = (m == 8'h00);
         OP_LOAD_WORK_SKIP_NULL: begin ew = m; skp = (m == 8'h00); end
         OP_SKIP_IF_NULL_BIT: skp = ~m[bs];
         default: ;
      endcase
      if (we) ewd = r;
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      mem_rdata <= m;
      imm_data <= imm;
      bit_sel <= bs;
      @(posedge clk);
      // operand bus no longer valid: show a changed value rather than the old one
      op_valid <= 1'b0;
      mem_rdata <= ~m;
      #1;
      chk(8'(mem_we), 8'(we), "mem_we");
      chk(mem_wdata, ewd, "mem_wdata");
      chk(work_register, ew, "work");
      chk(8'(flg), 8'(ef), "flags");
      chk(8'(skip_taken), 8'(skp), "skip");
      chk(8'(dummy_cycle), 8'(skp), "dummy");
      chk(8'(op_ready), 8'(!skp), "ready");
      if (skp) begin
         @(posedge clk);
         #1;
         chk(8'(dummy_cycle), 8'h00, "dummy len");
         chk(8'(op_ready), 8'h01, "ready back");
      end
   endtask

   task automatic reset_values();
      chk(8'(op_ready), 8'h01, "reset ready");
      chk(8'(mem_we), 8'h00, "reset we");
      chk(work_register, 8'h00, "reset work");
      chk(8'(flg), 8'h00, "reset flags");
      chk(8'({skip_taken, dummy_cycle}), 8'h00, "reset skip");
   endtask

   // subtraction chains, including borrow and multibyte-zero chaining
   task automatic sub_sequence();
      op_t ops [12] = '{OP_LOAD_WORK_SKIP_NULL, OP_MINUS_TO_WORK, OP_MINUS_TO_WORK,
         OP_LOAD_WORK_SKIP_NULL, OP_MINUS_TO_WORK, OP_MINUS_IMM_TO_WORK, OP_SUB_BORROW_MEM,
         OP_SUB_BORROW_MEM, OP_SUB_BORROW_MEM, OP_LOAD_WORK_SKIP_NULL, OP_MINUS_TO_MEMORY,
         OP_SUB_BORROW_MEM};
      logic [7:0] ms [12] = '{8'h05, 8'h03, 8'h05, 8'h80, 8'h01, 8'h7f, 8'h00, 8'h01,
         8'h00, 8'h10, 8'h01, 8'h0f};
      for (int i = 0; i < 12; i++) run(ops[i], ms[i], ms[i], 3'h0);
   endtask

   // byte-wide skips, moves and swaps; flags must ride through untouched
   task automatic skip_and_move();
      op_t ops [18] = '{OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO,
         OP_DEC_TO_WORK_SKIP, OP_DEC_TO_WORK_SKIP, OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO,
         OP_INC_TO_WORK_SKIP, OP_INC_TO_WORK_SKIP, OP_SKIP_NONZERO, OP_SKIP_NONZERO,
         OP_SKIP_IF_NULL, OP_SKIP_IF_NULL, OP_LOAD_WORK_SKIP_NULL, OP_LOAD_WORK_SKIP_NULL,
         OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_WORK, OP_SET_BYTE};
      logic [7:0] ms [18] = '{8'h01, 8'h05, 8'h00, 8'h01, 8'h00, 8'hff, 8'h7f, 8'hff,
         8'h00, 8'h00, 8'h5a, 8'h00, 8'h80, 8'h00, 8'h9c, 8'ha5, 8'h3c, 8'h12};
      for (int i = 0; i < 18; i++) run(ops[i], ms[i], 8'h00, 3'h0);
   endtask

   // every bit index for set-bit and both bit-test skips
   task automatic bit_forms();
      logic [7:0] one;
      for (int b = 0; b < 8; b++) begin
         one = 8'h01 << b;
         run(OP_SET_BIT, 8'h00, 8'h00, 3'(b));
         run(OP_SET_BIT, ~one, 8'h00, 3'(b));
         run(OP_SKIP_NONZERO_BIT, one, 8'h00, 3'(b));
         run(OP_SKIP_NONZERO_BIT, ~one, 8'h00, 3'(b));
         run(OP_SKIP_IF_NULL_BIT, ~one, 8'h00, 3'(b));
         run(OP_SKIP_IF_NULL_BIT, one, 8'h00, 3'(b));
      end
   endtask

   // next op held valid across the dummy cycle is refused once, then taken
   task automatic held_after_skip();
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= OP_DEC_SKIP_ZERO;
      mem_rdata <= 8'h01;
      @(posedge clk);
      op_code <= OP_SET_BYTE;
      mem_rdata <= 8'h3c;
      #1;
      chk(8'(dummy_cycle), 8'h01, "held dummy");
      chk(mem_wdata, 8'h00, "held dec");
      @(posedge clk);
      #1;
      chk(8'(mem_we), 8'h00, "refused in dummy");
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      chk(8'(mem_we), 8'h01, "held taken");
      chk(mem_wdata, 8'hff, "held value");
      ewd = 8'hff;
   endtask

   // clock enable low freezes the block even with an op offered
   task automatic clock_enable_hold();
      @(posedge clk);
      ce <= 1'b0;
      op_valid <= 1'b1;
      op_code <= OP_NIBBLE_EXCHANGE_WORK;
      mem_rdata <= 8'h4b;
      repeat (3) @(posedge clk);
      #1;
      chk(work_register, ew, "frozen work");
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      chk(work_register, 8'hb4, "ce resumes");
      ew = 8'hb4;
   endtask

   // reset in mid-run clears work and flags, even with clock enable low
   task automatic mid_reset();
      @(posedge clk);
      rst <= 1'b1;
      ce <= 1'b0;
      @(posedge clk);
      rst <= 1'b0;
      ce <= 1'b1;
      #1;
      ew = 8'h00;
      ef = 6'h00;
      ewd = 8'h00;
      reset_values();
      chk(mem_wdata, ewd, "reset wdata");
      run(OP_MINUS_IMM_TO_WORK, 8'h00, 8'h01, 3'h0);
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      op_valid = 1'b0;
      op_code = OP_NONE;
      mem_rdata = 8'h00;
      imm_data = 8'h00;
      bit_sel = 3'h0;
      n_errors = 0;
      num_checks = 0;
      cycles = 0;
      ef = 6'h00;
      ew = 8'h00;
      ewd = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      reset_values();
      sub_sequence();
      skip_and_move();
      bit_forms();
      held_after_skip();
      clock_enable_hold();
      mid_reset();
      wrap_up();
   end
endmodule // skip_subtract_swap_ops_tb_top
